/* sfcs_top.sv */
/*
 serial flash command sequencer: spi master toward the external serial
 flash, issuing identification, status, write enable, erase, program and
 read sequences, plus the file store allocation checks.
 assumes a mode-0 flash on the four-wire link and a requester that holds
 its command fields stable while req_i is high until ack.
*/
`timescale 1ns/1ps
module sfcs_top (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        req_i,
   input  wire logic [2:0]  cmd_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [7:0]  len_i,
   input  wire logic        raw_i,
   input  wire logic [23:0] store_size_i,
   input  wire logic [7:0]  file_count_i,
   input  wire logic [24:0] file_size_i,
   input  wire logic        file_safe_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        miso_i,
   output logic             ack_o,
   output logic             err_o,
   output logic             wr_take_o,
   output logic             rd_valid_o,
   output logic [7:0]       rd_data_o,
   output logic [23:0]      result_o,
   output logic             sck_o,
   output logic             cs_n_o,
   output logic             mosi_o
);
   typedef enum logic [3:0] {
      S_IDLE, S_WREN, S_WPOLL_OP, S_WPOLL_RD, S_CMD_OP, S_ADDR,
      S_DATA, S_BPOLL_OP, S_BPOLL_RD, S_GAP, S_DONE
   } sfcs_state_t;

   sfcs_state_t state;
   sfcs_state_t after_gap;
   logic [2:0]  cmd;
   logic [23:0] addr;
   logic [7:0]  left;
   logic [1:0]  abyte;
   logic [3:0]  div;
   logic        tick;
   logic        busy_shift;
   logic        byte_done;
   logic [7:0]  tx_byte;
   logic [7:0]  rx_byte;
   logic [2:0]  bitn;
   logic        load;
   logic [7:0]  next_tx;
   logic        sck_phase;
   logic [2:0]  miso_s;
   logic        miso_q;
   logic        miso_ok;

   localparam int BLOCK_SHIFT = sfcs_pkg::BLOCK_SHIFT;

   function automatic logic [25:0] alloc_bytes(input logic [24:0] sz,
                                               input logic safe);
      logic [25:0] raw;
      logic [25:0] blk;
      raw = safe ? {sz, 1'b0} : {1'b0, sz};
      blk = (raw + 26'h000_0FFF) >> BLOCK_SHIFT;
      blk = blk << BLOCK_SHIFT;
      if (blk == 26'h000_0000)
         blk = 26'h000_1000;
      if (safe && blk < sfcs_pkg::MIN_SAFE_SIZE)
         blk = sfcs_pkg::MIN_SAFE_SIZE;
      return blk;
   endfunction

   // miso from the pin: three flops, a level counts once two and three agree
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         miso_s <= 3'h0;
         miso_q <= 1'b0;
      end else begin
         miso_s <= {miso_s[1:0], miso_i};
         if (miso_s[2] == miso_s[1])
            miso_q <= miso_s[2];
      end
   end
   assign miso_ok = (miso_s[2] == miso_s[1]) ? miso_s[2] : miso_q;

   // half period divider for the link clock
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div  <= 4'h0;
         tick <= 1'b0;
      end else if (div == sfcs_pkg::SCK_HALF - 4'h1) begin
         div  <= 4'h0;
         tick <= 1'b1;
      end else begin
         div  <= div + 4'h1;
         tick <= 1'b0;
      end
   end

   // byte shifter, mode 0, msb first
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_shift <= 1'b0;
         byte_done  <= 1'b0;
         tx_byte    <= 8'h00;
         rx_byte    <= 8'h00;
         bitn       <= 3'h0;
         sck_phase  <= 1'b0;
         sck_o      <= 1'b0;
         mosi_o     <= 1'b0;
      end else begin
         byte_done <= 1'b0;
         if (load) begin
            busy_shift <= 1'b1;
            tx_byte    <= next_tx;
            mosi_o     <= next_tx[7];
            bitn       <= 3'h0;
            sck_phase  <= 1'b0;
         end else if (busy_shift && tick) begin
            if (!sck_phase) begin
               sck_o     <= 1'b1;
               sck_phase <= 1'b1;
               rx_byte   <= {rx_byte[6:0], miso_ok};
            end else begin
               sck_o     <= 1'b0;
               sck_phase <= 1'b0;
               if (bitn == sfcs_pkg::BIT_LAST) begin
                  busy_shift <= 1'b0;
                  byte_done  <= 1'b1;
               end else begin
                  bitn    <= bitn + 3'h1;
                  tx_byte <= {tx_byte[6:0], 1'b0};
                  mosi_o  <= tx_byte[6];
               end
            end
         end
      end
   end

   logic        start_ok;
   logic        is_write;
   logic [23:0] store_end;
   assign store_end = sfcs_pkg::STORE_BASE + store_size_i;
   assign is_write  = cmd_i == 3'(sfcs_pkg::SFCS_CMD_PROG) ||
                      cmd_i == 3'(sfcs_pkg::SFCS_CMD_SECT) ||
                      cmd_i == 3'(sfcs_pkg::SFCS_CMD_CHIP);
   // raw access may not touch the file store
   always_comb begin
      start_ok = 1'b1;
      if (raw_i && cmd_i != 3'(sfcs_pkg::SFCS_CMD_ID) &&
          cmd_i != 3'(sfcs_pkg::SFCS_CMD_STATUS) &&
          (addr_i < store_end ||
           cmd_i == 3'(sfcs_pkg::SFCS_CMD_CHIP)))
         start_ok = 1'b0;
      if (cmd_i == 3'(sfcs_pkg::SFCS_CMD_PROG) &&
          ({1'b0, len_i} == 9'h000 || {1'b0, len_i} >= sfcs_pkg::PAGE_LIMIT))
         start_ok = 1'b0;
      if (cmd_i > 3'(sfcs_pkg::SFCS_CMD_ALLOC))
         start_ok = 1'b0;
   end

   // opcode, address or data byte to load next
   always_comb begin
      next_tx = 8'h00;
      unique case (state)
         S_WREN:     next_tx = sfcs_pkg::OP_WRITE_EN;
         S_WPOLL_OP,
         S_BPOLL_OP: next_tx = sfcs_pkg::OP_READ_STATUS;
         S_CMD_OP: begin
            unique case (cmd)
               3'(sfcs_pkg::SFCS_CMD_ID):   next_tx = sfcs_pkg::OP_READ_ID;
               3'(sfcs_pkg::SFCS_CMD_STATUS):
                  next_tx = sfcs_pkg::OP_READ_STATUS;
               3'(sfcs_pkg::SFCS_CMD_READ): next_tx = sfcs_pkg::OP_READ_DATA;
               3'(sfcs_pkg::SFCS_CMD_PROG): next_tx = sfcs_pkg::OP_PAGE_PROG;
               3'(sfcs_pkg::SFCS_CMD_SECT): next_tx = sfcs_pkg::OP_SECT_ERASE;
               default:                     next_tx = sfcs_pkg::OP_CHIP_ERASE;
            endcase
         end
         S_ADDR: next_tx = (abyte == 2'h0) ? addr[23:16] :
                           (abyte == 2'h1) ? addr[15:8] : addr[7:0];
         S_DATA: next_tx = (cmd == 3'(sfcs_pkg::SFCS_CMD_PROG)) ?
                           wr_data_i : 8'h00;
         default: next_tx = 8'h00;
      endcase
   end

   logic active;
   assign load = active && !busy_shift && !byte_done && !cs_n_o &&
                 state != S_IDLE && state != S_GAP && state != S_DONE;

   // sequencer
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state      <= S_IDLE;
         after_gap  <= S_IDLE;
         cmd        <= 3'h0;
         addr       <= 24'h00_0000;
         left       <= 8'h00;
         abyte      <= 2'h0;
         active     <= 1'b0;
         cs_n_o     <= 1'b1;
         ack_o      <= 1'b0;
         err_o      <= 1'b0;
         wr_take_o  <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o  <= 8'h00;
         result_o   <= 24'h00_0000;
      end else begin
         ack_o      <= 1'b0;
         wr_take_o  <= 1'b0;
         rd_valid_o <= 1'b0;
         active     <= 1'b0;
         unique case (state)
            S_IDLE: if (req_i && !ack_o) begin
               cmd   <= cmd_i;
               left  <= len_i;
               abyte <= 2'h0;
               err_o <= 1'b0;
               if (cmd_i == 3'(sfcs_pkg::SFCS_CMD_SECT))
                  addr <= {addr_i[23:12], 12'h000};
               else
                  addr <= addr_i;
               if (cmd_i == 3'(sfcs_pkg::SFCS_CMD_ALLOC)) begin
                  result_o <= 24'(alloc_bytes(file_size_i, file_safe_i) >>
                                  BLOCK_SHIFT);
                  if (file_count_i >= sfcs_pkg::MAX_FILES)
                     err_o <= 1'b1;
                  if (file_size_i > sfcs_pkg::MAX_FILE_SIZE)
                     err_o <= 1'b1;
                  state <= S_DONE;
               end else if (!start_ok) begin
                  err_o <= 1'b1;
                  state <= S_DONE;
               end else begin
                  cs_n_o <= 1'b0;
                  state  <= is_write ? S_WREN : S_CMD_OP;
               end
            end
            S_WREN: if (byte_done) begin
               cs_n_o    <= 1'b1;
               after_gap <= S_WPOLL_OP;
               state     <= S_GAP;
            end else
               active <= 1'b1;
            S_WPOLL_OP, S_BPOLL_OP: if (byte_done) begin
               state <= (state == S_WPOLL_OP) ? S_WPOLL_RD : S_BPOLL_RD;
            end else
               active <= 1'b1;
            S_WPOLL_RD, S_BPOLL_RD: begin
               if (!busy_shift && !byte_done)
                  active <= 1'b1;
               if (byte_done) begin
                  cs_n_o <= 1'b1;
                  state  <= S_GAP;
                  if (state == S_WPOLL_RD)
                     after_gap <= rx_byte[sfcs_pkg::ST_WEL_BIT] ?
                                  S_CMD_OP : S_WPOLL_OP;
                  else
                     after_gap <= rx_byte[sfcs_pkg::ST_BUSY_BIT] ?
                                  S_BPOLL_OP : S_DONE;
               end
            end
            S_GAP: if (tick) begin
               state  <= after_gap;
               cs_n_o <= (after_gap == S_DONE);
            end
            S_CMD_OP: if (byte_done) begin
               if (cmd == 3'(sfcs_pkg::SFCS_CMD_CHIP)) begin
                  cs_n_o    <= 1'b1;
                  after_gap <= S_BPOLL_OP;
                  state     <= S_GAP;
               end else if (cmd == 3'(sfcs_pkg::SFCS_CMD_ID)) begin
                  left  <= 8'(sfcs_pkg::ID_BYTES);
                  state <= S_DATA;
               end else if (cmd == 3'(sfcs_pkg::SFCS_CMD_STATUS)) begin
                  left  <= 8'h01;
                  state <= S_DATA;
               end else
                  state <= S_ADDR;
            end else
               active <= 1'b1;
            S_ADDR: if (byte_done) begin
               abyte <= abyte + 2'h1;
               if (abyte == 2'h2) begin
                  if (cmd == 3'(sfcs_pkg::SFCS_CMD_SECT)) begin
                     cs_n_o    <= 1'b1;
                     after_gap <= S_BPOLL_OP;
                     state     <= S_GAP;
                  end else
                     state <= S_DATA;
               end
            end else
               active <= 1'b1;
            S_DATA: if (byte_done) begin
               if (cmd == 3'(sfcs_pkg::SFCS_CMD_PROG))
                  wr_take_o <= 1'b1;
               else begin
                  rd_valid_o <= 1'b1;
                  rd_data_o  <= rx_byte;
                  result_o   <= {result_o[15:0], rx_byte};
               end
               if (left != 8'h00)
                  left <= left - 8'h01;
               if (left == 8'h01 ||
                   (cmd == 3'(sfcs_pkg::SFCS_CMD_READ) && !req_i &&
                    left == 8'h00)) begin
                  cs_n_o <= 1'b1;
                  after_gap <= (cmd == 3'(sfcs_pkg::SFCS_CMD_PROG)) ?
                               S_BPOLL_OP : S_DONE;
                  state <= S_GAP;
               end
            end else if (left != 8'h00 ||
                         cmd == 3'(sfcs_pkg::SFCS_CMD_READ))
               active <= 1'b1;
            S_DONE: begin
               ack_o  <= 1'b1;
               cs_n_o <= 1'b1;
               state  <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   a_cs_frames_byte: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $rose(sck_o) |-> !cs_n_o)
      else $error("link clock pulsed outside chip select");
   a_sect_align: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_ADDR && cmd == 3'(sfcs_pkg::SFCS_CMD_SECT)) |->
      addr[11:0] == 12'h000)
      else $error("sector erase address not 4K aligned");
   a_wren_first: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_IDLE && req_i && !ack_o && start_ok && is_write &&
       cmd_i != 3'(sfcs_pkg::SFCS_CMD_ALLOC)) |=> state == S_WREN)
      else $error("write command without write enable");
   a_file_limit: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_IDLE && req_i && !ack_o &&
       cmd_i == 3'(sfcs_pkg::SFCS_CMD_ALLOC) && file_count_i >= 8'h80)
      |=> err_o ##1 ack_o && err_o)
      else $error("file created beyond count limit");
   a_size_limit: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_IDLE && req_i && !ack_o &&
       cmd_i == 3'(sfcs_pkg::SFCS_CMD_ALLOC) &&
       file_size_i > 25'h100_0000) |=> err_o)
      else $error("oversize file accepted");
   a_safe_min: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_IDLE && req_i && !ack_o && file_safe_i &&
       cmd_i == 3'(sfcs_pkg::SFCS_CMD_ALLOC)) |=> result_o >= 24'h00_0002)
      else $error("fail-safe file below two blocks");
   a_raw_guard: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_IDLE && req_i && !ack_o && raw_i &&
       cmd_i == 3'(sfcs_pkg::SFCS_CMD_CHIP)) |=> cs_n_o && err_o)
      else $error("raw chip erase reached the flash");
   a_wel_gate: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_WPOLL_RD && byte_done && !rx_byte[1]) |=>
      after_gap == S_WPOLL_OP)
      else $error("continued without write enable latch");
   a_busy_gate: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      (state == S_BPOLL_RD && byte_done && rx_byte[0]) |=>
      after_gap == S_BPOLL_OP)
      else $error("finished while flash busy");
endmodule

/* sfcs_pkg.sv */
/*
 package of the serial flash command sequencer: opcodes, status bit
 positions, file store limits, link timing and counter limits.
 assumes nothing of its surroundings.
*/
package sfcs_pkg;
   localparam logic [7:0]  OP_READ_ID     = 8'h9F;
   localparam logic [7:0]  OP_READ_STATUS = 8'h05;
   localparam logic [7:0]  OP_WRITE_EN    = 8'h06;
   localparam logic [7:0]  OP_CHIP_ERASE  = 8'hC7;
   localparam logic [7:0]  OP_READ_DATA   = 8'h03;
   localparam logic [7:0]  OP_PAGE_PROG   = 8'h02;
   localparam logic [7:0]  OP_SECT_ERASE  = 8'h20;
   localparam int          ST_BUSY_BIT    = 0;
   localparam int          ST_WEL_BIT     = 1;
   localparam int          ID_BYTES       = 3;
   localparam logic [8:0]  PAGE_LIMIT     = 9'h100;
   localparam logic [23:0] STORE_BASE     = 24'h00_0000;
   localparam int          BLOCK_SHIFT    = 12;
   localparam logic [7:0]  MAX_FILES      = 8'h80;
   localparam logic [24:0] MAX_FILE_SIZE  = 25'h100_0000;
   localparam logic [25:0] MIN_SAFE_SIZE  = 26'h000_2000;
   localparam int          SCK_HALF_NS    = 16;
   localparam int          CLK_NS         = 4;
   localparam int          SCK_HALF_CYC   = (SCK_HALF_NS + CLK_NS - 1)/CLK_NS;
   localparam logic [3:0]  SCK_HALF       = 4'(SCK_HALF_CYC);
   localparam logic [2:0]  BIT_LAST       = 3'h7;

   typedef enum logic [2:0] {
      SFCS_CMD_ID,
      SFCS_CMD_STATUS,
      SFCS_CMD_READ,
      SFCS_CMD_PROG,
      SFCS_CMD_SECT,
      SFCS_CMD_CHIP,
      SFCS_CMD_ALLOC
   } sfcs_cmd_t;
endpackage

/* sfcs_flash_model.sv */
/*
 behavioural serial flash for the sequencer bench: mode 0, msb first,
 id, status, write enable, erase, program and read.
 assumes sck idles low and stands still while chip select is high.
*/
`timescale 1ns/1ps
module sfcs_flash_model (
   input  wire logic       sck_i,
   input  wire logic       cs_n_i,
   input  wire logic       mosi_i,
   input  wire logic [3:0] delay_i,
   output logic            miso_o
);
   // identification value is arbitrary
   localparam logic [23:0] FLASH_ID = 24'h5A_C3E1;
   logic [7:0]  op = 8'h00;
   logic [7:0]  sh = 8'h00;
   logic [7:0]  tx = 8'h00;
   logic [23:0] addr = 24'h00_0000;
   logic [7:0]  pdata [4];
   logic        wel = 1'b0;
   logic        wel_at_cmd = 1'b0;
   int          bits, nb, pcnt, wel_wait, busy_cnt, polls, frames;

   function automatic logic [7:0] resp(input int n);
      case (op)
         8'h9F: resp = (n <= 3) ? FLASH_ID[8*(3-n) +: 8] : ~tx;
         8'h05: resp = {6'h00, wel && wel_wait == 0,
                        busy_cnt != 0};
         8'h03: resp = (n >= 4) ?
                       (addr[7:0] + 8'(n - 4)) ^ 8'h3C : ~tx;
         default: resp = ~tx;
      endcase
   endfunction

   initial miso_o = 1'b0;

   always @(negedge cs_n_i) begin
      bits = 0;
      nb = 0;
      op = 8'h00;
      frames++;
   end

   always @(posedge sck_i) begin
      if (!cs_n_i) begin
         sh = {sh[6:0], mosi_i};
         bits++;
         if (bits % 8 == 0) begin
            nb++;
            if (nb == 1) begin
               op = sh;
               if (sh == 8'h02) pcnt = 0;
            end else if (nb <= 4 && op inside {8'h03, 8'h02, 8'h20})
               addr = {addr[15:0], sh};
            else if (op == 8'h02 && pcnt < 4) begin
               pdata[pcnt] = sh;
               pcnt++;
            end else if (op == 8'h05) begin
               polls++;
               if (wel_wait > 0) wel_wait--;
               if (busy_cnt > 0) busy_cnt--;
            end
            tx = resp(nb);
         end
      end
   end

   always @(negedge sck_i) begin
      if (!cs_n_i) begin
         miso_o = tx[7];
         tx = {tx[6:0], ~tx[7]};
      end
   end

   // released line shows the inverse, not the last bit
   always @(posedge cs_n_i) begin
      miso_o = ~miso_o;
      if (op == 8'h06) begin
         wel = 1'b1;
         wel_wait = delay_i;
      end else if (op inside {8'h02, 8'h20, 8'hC7}) begin
         wel_at_cmd = wel && wel_wait == 0;
         wel = 1'b0;
         busy_cnt = delay_i + 1;
      end
   end
endmodule

/* testbench.sv */
/*
 self-checking bench of the serial flash command sequencer.
 assumes the flash model beside it and the package constants.
*/
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [7:0]  cnt;
      logic [24:0] size;
      logic        safe;
      logic [23:0] blocks;
      logic        err;
   } sfcs_row_t;
   sfcs_row_t rows [10] = '{
      '{8'h00, 25'h000_0001, 1'b0, 24'h00_0001, 1'b0},
      '{8'h00, 25'h000_1000, 1'b0, 24'h00_0001, 1'b0},
      '{8'h00, 25'h000_1001, 1'b0, 24'h00_0002, 1'b0},
      '{8'h05, 25'h000_0000, 1'b0, 24'h00_0001, 1'b0},
      '{8'h00, 25'h000_0001, 1'b1, 24'h00_0002, 1'b0},
      '{8'h00, 25'h000_1001, 1'b1, 24'h00_0003, 1'b0},
      '{8'h7F, 25'h100_0000, 1'b0, 24'h00_1000, 1'b0},
      '{8'h80, 25'h000_0001, 1'b0, 24'h00_0001, 1'b1},
      '{8'h00, 25'h100_0001, 1'b0, 24'h00_1001, 1'b1},
      '{8'h00, 25'h100_0000, 1'b1, 24'h00_2000, 1'b0}};
   typedef struct packed {
      logic [2:0]  cmd;
      logic [23:0] addr;
      logic [7:0]  len;
      logic        raw;
      logic        err;
   } sfcs_ref_t;
   sfcs_ref_t refs [5] = '{
      '{3'h2, 24'h00_0FFF, 8'h01, 1'b1, 1'b1},
      '{3'h2, 24'h00_1000, 8'h01, 1'b1, 1'b0},
      '{3'h5, 24'h00_2000, 8'h00, 1'b1, 1'b1},
      '{3'h3, 24'h00_2000, 8'h00, 1'b0, 1'b1},
      '{3'h7, 24'h00_2000, 8'h01, 1'b0, 1'b1}};
   logic        sys_clk, sys_rst, req, raw, file_safe, miso;
   logic        ack, err, wr_take, rd_valid, sck, cs_n, mosi;
   logic [2:0]  cmd;
   logic [23:0] addr, store_size, result;
   logic [7:0]  len, file_count, wr_data, rd_data;
   logic [24:0] file_size;
   logic [3:0]  delay;
   logic [7:0]  rd_q [8];
   int          bad_count, checked, nrd, nwr, f0, p0, stop_at;

   sfcs_top u_dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .req_i(req),
      .cmd_i(cmd), .addr_i(addr), .len_i(len), .raw_i(raw),
      .store_size_i(store_size), .file_count_i(file_count),
      .file_size_i(file_size), .file_safe_i(file_safe), .wr_data_i(wr_data),
      .miso_i(miso), .ack_o(ack), .err_o(err), .wr_take_o(wr_take),
      .rd_valid_o(rd_valid), .rd_data_o(rd_data), .result_o(result),
      .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
   sfcs_flash_model u_flash (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
      .delay_i(delay), .miso_o(miso));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic end_sim();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // holds request and fields until ack, drops request once stop_at bytes are read if stop_at is set, feeds bytes on wr_take
   task automatic run(input logic [2:0] c, input logic [23:0] a,
                      input logic [7:0] n);
      int i;
      nrd = 0;
      nwr = 0;
      f0 = u_flash.frames;
      p0 = u_flash.polls;
      @(negedge sys_clk);
      cmd = c;
      addr = a;
      len = n;
      wr_data = 8'hA0;
      req = 1'b1;
      for (i = 0; i < 4000; i++) begin
         @(negedge sys_clk);
         if (rd_valid && nrd < 8) begin
            rd_q[nrd] = rd_data;
            nrd++;
            if (stop_at != 0 && nrd == stop_at)
               req = 1'b0;
         end
         if (wr_take) begin
            nwr++;
            wr_data = 8'hA0 + 8'(nwr);
         end
         if (ack) break;
      end
      req = 1'b0;
      raw = 1'b0;
      if (i >= 4000) begin
         bad_count++;
         end_sim();
      end
   endtask

   initial begin
      {req, raw, file_safe, cmd, addr, len, file_count} = '0;
      {file_size, wr_data, delay} = '0;
      store_size = 24'h00_1000;
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk(cs_n, 1'b1);
      chk({sck, mosi, ack, err}, 4'h0);
      sys_rst = 1'b0;
      $display("test reset done");
      foreach (rows[k]) begin
         file_count = rows[k].cnt;
         file_size = rows[k].size;
         file_safe = rows[k].safe;
         run(3'h6, 24'h00_0000, 8'h00);
         chk(result, rows[k].blocks);
         chk(err, rows[k].err);
      end
      $display("test alloc done");
      run(3'h0, 24'h00_0000, 8'h00);
      chk(result, u_flash.FLASH_ID);
      chk(u_flash.op, 8'h9F);
      run(3'h1, 24'h00_0000, 8'h00);
      chk(u_flash.op, 8'h05);
      chk(u_flash.polls > p0, 1'b1);
      run(3'h2, 24'h00_5678, 8'h03);
      chk(nrd, 3);
      for (int k = 0; k < 3; k++)
         chk(rd_q[k], (8'h78 + 8'(k)) ^ 8'h3C);
      chk(u_flash.addr, 24'h00_5678);
      stop_at = 2;
      run(3'h2, 24'h00_2000, 8'h00);
      stop_at = 0;
      chk(nrd, 3);
      chk(rd_q[2], 8'h02 ^ 8'h3C);
      $display("test id status read done");
      delay = 4'h3;
      run(3'h3, 24'h01_0203, 8'h02);
      chk(u_flash.wel_at_cmd, 1'b1);
      chk({u_flash.pcnt[7:0], u_flash.pdata[0], u_flash.pdata[1]},
          24'h02_A0A1);
      chk(u_flash.addr, 24'h01_0203);
      chk(nwr, 2);
      chk(u_flash.busy_cnt, 0);
      for (int d = 0; d < 2; d++) begin
         delay = d ? 4'h3 : 4'h0;
         run(3'h4, 24'h01_2345, 8'h00);
         chk(u_flash.addr, 24'h01_2000);
         chk(u_flash.wel_at_cmd, 1'b1);
         chk(u_flash.busy_cnt, 0);
      end
      run(3'h5, 24'h00_0000, 8'h00);
      chk(u_flash.polls - p0 >= 9, 1'b1);
      chk(u_flash.busy_cnt, 0);
      chk(u_flash.wel_at_cmd, 1'b1);
      $display("test program erase done");
      foreach (refs[k]) begin
         raw = refs[k].raw;
         run(refs[k].cmd, refs[k].addr, refs[k].len);
         chk(err, refs[k].err);
         chk(u_flash.frames == f0, refs[k].err);
      end
      $display("test refusal done");
      delay = 4'h0;
      @(negedge sys_clk);
      cmd = 3'h2;
      len = 8'h00;
      req = 1'b1;
      repeat (40) @(negedge sys_clk);
      sys_rst = 1'b1;
      req = 1'b0;
      @(negedge sys_clk);
      chk(cs_n, 1'b1);
      chk({sck, ack}, 2'h0);
      sys_rst = 1'b0;
      run(3'h0, 24'h00_0000, 8'h00);
      chk(result, u_flash.FLASH_ID);
      $display("test mid reset done");
      end_sim();
   end
endmodule
